// ### hw/mcu_regs.svh
// Purpose: constants for the multicycle custom operation unit
// Assumes: one clock, synchronous active-high reset
// Notes:   included by bare name
`ifndef MCU_REGS_SVH
`define MCU_REGS_SVH

`define MCU_DATA_W      32
`define MCU_SEL_W       2
`define MCU_REG_W       5
`define MCU_NREGS       32
`define MCU_BASE_INDEX  8'h1c
`define MCU_FIXED_N     4
`define MCU_MIN_CYCLES  2
`define MCU_OP_BITREV   2'h0
`define MCU_OP_BYTESWAP 2'h1
`define MCU_OP_HALFSWAP 2'h2
`define MCU_OP_RSVD     2'h3
`define MCU_REG_RST     32'h0000_0000

`endif

// ### hw/mcu_pkg.sv
// Purpose: shared types for the custom operation unit
// Assumes: constants come from mcu_regs.svh
// Notes:   types only
`include "mcu_regs.svh"
package mcu_pkg;
    typedef logic [`MCU_DATA_W-1:0] mcu_word_t;
    typedef logic [`MCU_SEL_W-1:0]  mcu_sel_t;
    typedef logic [`MCU_REG_W-1:0]  mcu_rnum_t;
    typedef enum logic [1:0]
    {
        MCU_IDLE = 2'b00,
        MCU_BUSY = 2'b01,
        MCU_DONE = 2'b10
    } mcu_state_t;
endpackage

// ### hw/mcu_if.sv
// Purpose: link between processor issue side and custom operation unit
// Assumes: single clock domain
// Notes:   one modport per party
`timescale 1ns/1ps
`default_nettype none
interface mcu_if;
    logic               clk_en;
    logic               start;
    logic               done;
    mcu_pkg::mcu_word_t dataa;
    mcu_pkg::mcu_word_t datab;
    mcu_pkg::mcu_word_t result;
    mcu_pkg::mcu_sel_t  n;
    logic               readra;
    logic               readrb;
    logic               writerc;
    mcu_pkg::mcu_rnum_t a;
    mcu_pkg::mcu_rnum_t b;
    mcu_pkg::mcu_rnum_t c;
    modport unit
    (
        input  clk_en, start, dataa, datab, n, readra, readrb, writerc, a, b, c,
        output done, result
    );
    modport proc
    (
        output clk_en, start, dataa, datab, n, readra, readrb, writerc, a, b, c,
        input  done, result
    );
endinterface
`default_nettype wire

// ### hw/mcu_swap_core.sv
// Purpose: swap datapath selected by extension index
// Assumes: operand stable while used
// Notes:   pure combinational function of operand and index
`timescale 1ns/1ps
`default_nettype none
`include "mcu_regs.svh"
module mcu_swap_core
(
    input  wire mcu_pkg::mcu_word_t operand,
    input  wire mcu_pkg::mcu_sel_t  sel,
    output logic                    valid_op,
    output mcu_pkg::mcu_word_t      swapped
);
    function automatic mcu_pkg::mcu_word_t bit_rev(input mcu_pkg::mcu_word_t v);
        mcu_pkg::mcu_word_t r;
        r = '0;
        for (int i = 0; i < `MCU_DATA_W; i++)
        begin
            r[i] = v[`MCU_DATA_W-1-i];
        end
        return r;
    endfunction

    wire mcu_pkg::mcu_word_t byte_sw = {operand[7:0], operand[15:8],
                                        operand[23:16], operand[31:24]};
    wire mcu_pkg::mcu_word_t half_sw = {operand[15:0], operand[31:16]};

    // operation select, fourth code reserved
    assign swapped  = (sel == `MCU_OP_BITREV)   ? bit_rev(operand) :
                      (sel == `MCU_OP_BYTESWAP) ? byte_sw :
                      (sel == `MCU_OP_HALFSWAP) ? half_sw : `MCU_REG_RST;
    assign valid_op = (sel != `MCU_OP_RSVD);
endmodule
`default_nettype wire

// ### hw/mcu_unit.sv
// Purpose: variable-length multicycle extended custom operation unit
// Assumes: processor keeps operands, index, flags stable from start to done
// Notes:   internal 32-entry register file, clk_en gates every flop
//          reserved index returns zero
//          local write lands on the done edge
//          operand b is read but no op uses it
`timescale 1ns/1ps
`default_nettype none
`include "mcu_regs.svh"
module mcu_unit
(
    input  wire logic  clock,
    input  wire logic  rst,
    mcu_if.unit        link
);
    ////////////////////////////////////////////////////////////////////////
    // storage
    mcu_pkg::mcu_word_t  regfile [`MCU_NREGS];
    mcu_pkg::mcu_state_t state;
    mcu_pkg::mcu_state_t next_state;
    mcu_pkg::mcu_word_t  res_q;
    mcu_pkg::mcu_word_t  next_res;
    logic [`MCU_REG_W-1:0] dest_q;
    logic [`MCU_REG_W-1:0] next_dest;
    logic                dest_int_q;
    logic                next_dest_int;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // operand source pick
    function automatic mcu_pkg::mcu_word_t pick_operand
    (
        input logic               from_bus,
        input mcu_pkg::mcu_word_t bus_word,
        input mcu_pkg::mcu_word_t file_word
    );
        if (from_bus)
        begin
            return bus_word;
        end
        return file_word;
    endfunction

    // one-hot entry decode
    function automatic logic [`MCU_NREGS-1:0] entry_select
    (
        input mcu_pkg::mcu_rnum_t num
    );
        logic [`MCU_NREGS-1:0] hit;
        hit = '0;
        for (int i = 0; i < `MCU_NREGS; i++)
        begin
            hit[i] = (int'(num) == i);
        end
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control decode
    wire logic                  is_idle     = (state == mcu_pkg::MCU_IDLE);
    wire logic                  is_done     = (state == mcu_pkg::MCU_DONE);
    wire logic                  accept      = link.clk_en && link.start && is_idle;
    wire logic                  write_local = link.clk_en && is_done && dest_int_q;
    // write strobe per entry on the done edge
    wire logic [`MCU_NREGS-1:0] entry_we    = write_local ? entry_select(dest_q) : '0;

    ////////////////////////////////////////////////////////////////////////
    // operand selection
    wire mcu_pkg::mcu_word_t file_a = regfile[link.a];
    wire mcu_pkg::mcu_word_t file_b = regfile[link.b];
    wire mcu_pkg::mcu_word_t op_a   = pick_operand(link.readra, link.dataa, file_a);
    wire mcu_pkg::mcu_word_t op_b   = pick_operand(link.readrb, link.datab, file_b);
    wire mcu_pkg::mcu_word_t swapped;
    wire logic               valid_op;
    wire logic               unused_b = ^op_b;
    // reserved index yields zero
    wire mcu_pkg::mcu_word_t op_out   = valid_op ? swapped : `MCU_REG_RST;

    mcu_swap_core mcu_swap_core_i
    (
        .operand  (op_a),
        .sel      (link.n),
        .valid_op (valid_op),
        .swapped  (swapped)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencing: start cycle captures, next cycle asserts done
    always_comb
    begin
        next_state    = state;
        next_res      = res_q;
        next_dest     = dest_q;
        next_dest_int = dest_int_q;
        case (state)
            mcu_pkg::MCU_IDLE:
            begin
                if (accept)
                begin
                    next_state    = mcu_pkg::MCU_DONE;
                    next_res      = op_out;
                    next_dest     = link.c;
                    next_dest_int = ~link.writerc;
                end
            end
            mcu_pkg::MCU_DONE:
            begin
                next_state = mcu_pkg::MCU_IDLE;
            end
            default:
            begin
                next_state = mcu_pkg::MCU_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state <= mcu_pkg::MCU_IDLE;
        end
        else if (link.clk_en)
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result register, held until the next operation
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            res_q <= `MCU_REG_RST;
        end
        else if (link.clk_en)
        begin
            res_q <= next_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // destination captured with start
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            dest_q     <= '0;
            dest_int_q <= 1'b0;
        end
        else if (link.clk_en)
        begin
            dest_q     <= next_dest;
            dest_int_q <= next_dest_int;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal register file, written when destination is local
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < `MCU_NREGS; i++)
        begin
            if (rst)
            begin
                regfile[i] <= `MCU_REG_RST;
            end
            else if (entry_we[i])
            begin
                regfile[i] <= res_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answer to processor
    assign link.done   = is_done;
    assign link.result = res_q;
endmodule
`default_nettype wire

// ### hw/mcu_proc_end.sv
// Purpose: processor side issuing operations to the custom unit
// Assumes: user holds req until ack pulse
// Notes:   drives start for one clk_en cycle, held through stall, holds operands until done
`timescale 1ns/1ps
`default_nettype none
module mcu_proc_end
(
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                stall,
    input  wire logic                req,
    input  wire mcu_pkg::mcu_word_t  req_dataa,
    input  wire mcu_pkg::mcu_word_t  req_datab,
    input  wire mcu_pkg::mcu_sel_t   req_n,
    input  wire logic                req_readra,
    input  wire logic                req_readrb,
    input  wire logic                req_writerc,
    input  wire mcu_pkg::mcu_rnum_t  req_a,
    input  wire mcu_pkg::mcu_rnum_t  req_b,
    input  wire mcu_pkg::mcu_rnum_t  req_c,
    output logic                     busy,
    output logic                     ack,
    output mcu_pkg::mcu_word_t       rsp_result,
    mcu_if.proc                      link
);
    logic               active;
    logic               start_q;
    mcu_pkg::mcu_word_t da;
    mcu_pkg::mcu_word_t db;
    mcu_pkg::mcu_sel_t  nq;
    logic [2:0]         flags;
    mcu_pkg::mcu_rnum_t ra;
    mcu_pkg::mcu_rnum_t rb;
    mcu_pkg::mcu_rnum_t rc;

    wire logic take   = req && !active && !stall;
    wire logic finish = active && !start_q && !stall && link.done;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            active     <= 1'b0;
            start_q    <= 1'b0;
            ack        <= 1'b0;
            rsp_result <= '0;
            da         <= '0;
            db         <= '0;
            nq         <= '0;
            flags      <= 3'h7;
            ra         <= '0;
            rb         <= '0;
            rc         <= '0;
        end
        else
        begin
            ack <= finish;
            if (!stall)
            begin
                start_q <= take;
            end
            if (take)
            begin
                active <= 1'b1;
                da     <= req_dataa;
                db     <= req_datab;
                nq     <= req_n;
                flags  <= {req_readra, req_readrb, req_writerc};
                ra     <= req_a;
                rb     <= req_b;
                rc     <= req_c;
            end
            else if (finish)
            begin
                active     <= 1'b0;
                rsp_result <= link.result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign busy         = active;
    assign link.clk_en  = !stall;
    assign link.start   = start_q;
    assign link.dataa   = da;
    assign link.datab   = db;
    assign link.n       = nq;
    assign link.readra  = flags[2];
    assign link.readrb  = flags[1];
    assign link.writerc = flags[0];
    assign link.a       = ra;
    assign link.b       = rb;
    assign link.c       = rc;
endmodule
`default_nettype wire

// ### test/mcu_assertions.sv
// Purpose: concurrent checks on the unit link
// Assumes: one clock, rst synchronous active high
// Notes:   instanced beside the link interface
`timescale 1ns/1ps
`default_nettype none
module mcu_assertions
(
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               clk_en,
    input wire logic               start,
    input wire logic               done,
    input wire mcu_pkg::mcu_word_t dataa,
    input wire mcu_pkg::mcu_word_t result,
    input wire mcu_pkg::mcu_sel_t  n,
    input wire logic               readra,
    input wire logic               writerc,
    input wire mcu_pkg::mcu_rnum_t a,
    input wire mcu_pkg::mcu_rnum_t c
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire mcu_pkg::mcu_word_t exp_res;
    wire mcu_pkg::mcu_word_t rev_bits;
    wire mcu_pkg::mcu_word_t rev_bytes;
    assign rev_bits  = {<<{dataa}};
    assign rev_bytes = {<<8{dataa}};
    assign exp_res   = (n == 2'h0) ? rev_bits :
                       (n == 2'h1) ? rev_bytes :
                       (n == 2'h2) ? {dataa[15:0], dataa[31:16]} : 32'h0;
    ////////////////////////////////////////////////////////////////////////////
    property p_start_one;
        start && clk_en |=> !start;
    endproperty
    a_start_one: assert property (p_start_one) else $error("start too long");
    property p_start_done;
        start && clk_en |=> done;
    endproperty
    a_start_done: assert property (p_start_done) else $error("done late");
    property p_done_cause;
        $rose(done) |-> $past(start) && $past(clk_en);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done without start");
    property p_done_pulse;
        done && clk_en |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_done_hold;
        done && !clk_en |=> done;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done lost in stall");
    property p_result_hold;
        !clk_en |=> $stable(result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved");
    property p_result_val;
        done && readra |-> result == exp_res;
    endproperty
    a_result_val: assert property (p_result_val) else $error("bad result");
    property p_stable;
        done |-> $stable(dataa) && $stable(n) && $stable({readra, writerc, a, c});
    endproperty
    a_stable: assert property (p_stable) else $error("inputs moved");
    property p_reset;
        $past(rst) |-> !done && !start && result == 32'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset not cleared");
endmodule
`default_nettype wire

// ### test/multicycle_custom_op_unit_bench.sv
// Purpose: bench for the unit and its issue side
// Assumes: 50 ns clock, synchronous reset
// Notes:   drives the issue side user ports only
`timescale 1ns/1ps
`default_nettype none
module multicycle_custom_op_unit_bench;
    logic               clock = 1'b0;
    logic               rst = 1'b1;
    logic               stall = 1'b0;
    logic               req = 1'b0;
    mcu_pkg::mcu_word_t req_dataa = 32'h0;
    mcu_pkg::mcu_sel_t  req_n = 2'h0;
    logic               req_readra = 1'b1;
    logic               req_writerc = 1'b1;
    mcu_pkg::mcu_rnum_t req_a = 5'h00;
    mcu_pkg::mcu_rnum_t req_c = 5'h00;
    logic               busy;
    logic               ack;
    mcu_pkg::mcu_word_t rsp_result;
    mcu_pkg::mcu_word_t res;
    int                 cyc;
    int                 fail_count = 0;
    int                 samples_checked = 0;
    always #25 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    mcu_if mcu_if_i ();
    mcu_unit mcu_unit_i (.clock(clock), .rst(rst), .link(mcu_if_i));
    mcu_proc_end mcu_proc_end_i (.clock(clock), .rst(rst), .stall(stall), .req(req),
        .req_dataa(req_dataa), .req_datab(32'h0), .req_n(req_n), .req_readra(req_readra),
        .req_readrb(1'b1), .req_writerc(req_writerc), .req_a(req_a), .req_b(5'h00),
        .req_c(req_c), .busy(busy), .ack(ack), .rsp_result(rsp_result), .link(mcu_if_i));
    mcu_assertions mcu_assertions_i (.clock(clock), .rst(rst), .clk_en(mcu_if_i.clk_en),
        .start(mcu_if_i.start), .done(mcu_if_i.done), .dataa(mcu_if_i.dataa),
        .result(mcu_if_i.result), .n(mcu_if_i.n), .readra(mcu_if_i.readra),
        .writerc(mcu_if_i.writerc), .a(mcu_if_i.a), .c(mcu_if_i.c));
    ////////////////////////////////////////////////////////////////////////////
    function automatic mcu_pkg::mcu_word_t swap_of(input mcu_pkg::mcu_word_t d,
                                                   input mcu_pkg::mcu_sel_t  s);
        case (s)
            2'h0: swap_of = {<<{d}};
            2'h1: swap_of = {<<8{d}};
            2'h2: swap_of = {d[15:0], d[31:16]};
            default: swap_of = 32'h0;
        endcase
    endfunction
    task automatic check(input mcu_pkg::mcu_word_t got, input mcu_pkg::mcu_word_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one operation; req stays high so the next call follows back to back
    task automatic op(input mcu_pkg::mcu_word_t d, input mcu_pkg::mcu_sel_t s,
                      input logic ra, input logic wc, input mcu_pkg::mcu_rnum_t an,
                      input mcu_pkg::mcu_rnum_t cn, input int st);
        req_dataa = d;
        req_n = s;
        req_readra = ra;
        req_writerc = wc;
        req_a = an;
        req_c = cn;
        req = 1'b1;
        cyc = 0;
        do
        begin
            @(posedge clock);
            #1;
            cyc++;
            if (cyc == 1 && st > 0)
                stall = 1'b1;
            if (cyc == 1 + st)
                stall = 1'b0;
            if (cyc > 40)
            begin
                fail_count++;
                end_sim();
            end
        end
        while (ack !== 1'b1);
        res = rsp_result;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clock);
        #1;
        rst = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            op(32'h1234_5678, mcu_pkg::mcu_sel_t'(k), 1'b1, 1'b1, 5'h00, 5'h00, 0);
            check(res, swap_of(32'h1234_5678, mcu_pkg::mcu_sel_t'(k)));
            check(32'(cyc), 32'h3);
        end
        op(32'h0000_00ff, 2'h0, 1'b1, 1'b1, 5'h00, 5'h00, 3);
        check(res, 32'hff00_0000);
        check(32'(cyc), 32'h6);
        op(32'hffff_ffff, 2'h0, 1'b0, 1'b1, 5'h00, 5'h00, 0);
        check(res, 32'h0);
        op(32'hcafe_0001, 2'h1, 1'b1, 1'b0, 5'h00, 5'h1f, 0);
        check(res, 32'h0100_feca);
        op(32'h0, 2'h2, 1'b0, 1'b1, 5'h1f, 5'h00, 0);
        check(res, 32'hfeca_0100);
        op(32'hcafe_0001, 2'h1, 1'b1, 1'b0, 5'h00, 5'h1f, 0);
        // reset lands in the middle of the retaken write
        repeat (2) @(posedge clock);
        #1;
        req = 1'b0;
        rst = 1'b1;
        repeat (16) @(posedge clock);
        #1;
        rst = 1'b0;
        check({31'h0, busy}, 32'h0);
        op(32'h0, 2'h2, 1'b0, 1'b1, 5'h1f, 5'h00, 0);
        check(res, 32'h0);
        check(32'(cyc), 32'h3);
        req = 1'b0;
        repeat (4) @(posedge clock);
        end_sim();
    end
endmodule
`default_nettype wire
